//--- verilog/bec_regs.svh
// Purpose: Register map, field positions, reset values and timing figures of the bit error classifier.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus, one register per aligned word.
// Notes:   Definitions only.
`ifndef BEC_REGS_SVH
`define BEC_REGS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define BEC_A_CTRL       8'h00
`define BEC_A_DATA_LEN   8'h04
`define BEC_A_MASK_ADDR  8'h08
`define BEC_A_MASK_DATA  8'h0C
`define BEC_A_STATUS     8'h10
`define BEC_A_INT_EN     8'h14
`define BEC_A_INT_CLR    8'h18
`define BEC_A_SYNC       8'h1C
`define BEC_A_ERR_TOTAL  8'h20
`define BEC_A_ERR_A      8'h24
`define BEC_A_ERR_B      8'h28
`define BEC_A_EI_CNT     8'h2C
`define BEC_A_EFI_CNT    8'h30

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define BEC_C_TRANS      0
`define BEC_C_COMB       1
`define BEC_C_WMASK      2
`define BEC_C_WGATE      3
`define BEC_C_AUTO       4
`define BEC_C_EISEL      5
`define BEC_C_CLR        7
`define BEC_C_RESYNC     8
`define BEC_C_THR        9
`define BEC_C_PAT        13
`define BEC_C_FRAME      15
`define BEC_MA_GATE      31
`define BEC_MA_AW        16

// ----------------------------------------------------------------
// Status and interrupt bits
// ----------------------------------------------------------------
`define BEC_S_LOST       0
`define BEC_S_GAIN       1
`define BEC_S_REFUSE     2
`define BEC_NUM_EV       3

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define BEC_DLEN_RST     19'h0_0080
`define BEC_THR_INT      4'h0
`define BEC_THR_NMIN     4'h2
`define BEC_THR_NMAX     4'h8
`define BEC_PAT_PRBS     2'h1
`define BEC_PAT_MIXED    2'h2

// ----------------------------------------------------------------
// Timing: clock rate and interval lengths in milliseconds
// ----------------------------------------------------------------
`define BEC_CLK_KHZ      125000
`define BEC_IVL0_MS      1
`define BEC_IVL1_MS      10
`define BEC_IVL2_MS      100
`define BEC_IVL3_MS      1000

// ----------------------------------------------------------------
// Internal sync table: error count over valid bit count
// ----------------------------------------------------------------
`define BEC_PRBS_LOSS_ERR   (128 * 2000)
`define BEC_PRBS_LOSS_WIN   (2048 * 5000)
`define BEC_PRBS_GAIN_ERR   128
`define BEC_PRBS_GAIN_WIN   (2048 * 4)
`define BEC_FRM_LOSS_ERR    (128 * 200)
`define BEC_FRM_LOSS_WIN    (2048 * 64000)
`define BEC_FRM_GAIN_ERR    128
`define BEC_FRM_GAIN_MUL    2
`define BEC_DEC_SCALE       10

`endif

//--- verilog/bec_pkg.sv
// Purpose: Types shared by the bit error classifier.
// Assumes: Field widths fixed here; memory depth set by module parameter.
// Notes:   None.
package bec_pkg;

  typedef enum logic [1:0] {
    BEC_SY_HUNT = 2'b00,
    BEC_SY_LOCK = 2'b01,
    BEC_SY_LOST = 2'b10
  } bec_sync_e;

  typedef struct packed {
    logic        cls_trans;
    logic        combined;
    logic        wmask_en;
    logic        wgate_en;
    logic        auto_sync;
    logic [1:0]  ei_sel;
    logic [3:0]  thr_sel;
    logic [1:0]  pat_kind;
    logic        frame_mode;
    logic [18:0] data_len;
    logic [15:0] mask_addr;
    logic        mask_gate;
    logic [2:0]  int_en;
    logic [2:0]  status;
    logic        ack;
    logic [31:0] dat;
    bec_sync_e   sync;
    logic [31:0] win_cnt;
    logic [31:0] win_err;
    logic        p_valid;
    logic        p_rx;
    logic        p_exp;
    logic        p_prev;
    logic [4:0]  p_bit;
    logic        err_flag;
    logic        resync;
    logic [31:0] err_total;
    logic [31:0] err_a;
    logic [31:0] err_b;
    logic [31:0] ivl_cnt;
    logic        ivl_hit;
    logic [31:0] ei_cnt;
    logic [31:0] efi_cnt;
  } bec_state_s;

endpackage : bec_pkg

//--- verilog/bec_mask_mem.sv
// Purpose: Per-word pattern mask and word gate store, one word per 32 pattern bits.
// Assumes: One write port, one read port, same clock.
// Notes:   Read data come from a register, one cycle after the address.
`timescale 1ns/1ps
`default_nettype none

module bec_mask_mem #(
  parameter int W  = 33,
  parameter int AW = 6
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [W-1:0]  wbit_en_i,
  // Read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  // Bit-enabled write lets a refused mask update still change the gate bit
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < W; i++) begin
      if (we_i && wbit_en_i[i]) begin
        mem[waddr_i][i] <= wdata_i[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule : bec_mask_mem

`default_nettype wire

//--- verilog/bec_top.sv
// Purpose: Receive-side bit error classification, interval counting, masking and sync supervision.
// Assumes: Received and expected bits arrive on clk_i, already retimed to the recovered clock.
// Notes:   Registers over classic Wishbone; one level interrupt.
// What this block does
// - Insertion: expected 0 got 1; omission: expected 1 got 0.
// - Transition mode counts errors on changing and holding expected bits separately.
// - Transition classification cannot be chosen in dual-channel combined mode.
// - Selectable 1, 10, 100 or 1000 ms intervals; counters report elapsed intervals.
// - With 1 s setting, each second with any errors records one, else zero.
// - Mask enabled excludes bits whose mask is 1; disabled masks nothing.
// - Mask cannot change with PRBS or mixed pattern, or once capture started.
// - Word gate enables or disables measurement per 32-bit pattern segment.
// - Auto resync restarts acquisition on sync loss; off means no automatic resync.
// - Resync threshold is ten to minus N, N 2 to 8, or internal table.
// - Sync lost when rate exceeds threshold; acquired when at or below it.
// - Internal table, PRBS: loss at 2.5e-2, regain at 1.56e-2.
// - Internal table, frame: loss 1.95e-4, regain 128 errors per 2*DataLength valid bits.
`timescale 1ns/1ps
`default_nettype none
`include "bec_regs.svh"

module bec_top
  import bec_pkg::*;
#(
  parameter int MEM_AW         = 6,
  parameter int IVL0_CYC       = `BEC_IVL0_MS * `BEC_CLK_KHZ,
  parameter int IVL1_CYC       = `BEC_IVL1_MS * `BEC_CLK_KHZ,
  parameter int IVL2_CYC       = `BEC_IVL2_MS * `BEC_CLK_KHZ,
  parameter int IVL3_CYC       = `BEC_IVL3_MS * `BEC_CLK_KHZ,
  parameter int PRBS_LOSS_WIN  = `BEC_PRBS_LOSS_WIN,
  parameter int PRBS_GAIN_WIN  = `BEC_PRBS_GAIN_WIN,
  parameter int FRM_LOSS_WIN   = `BEC_FRM_LOSS_WIN,
  parameter int DEC_SCALE      = `BEC_DEC_SCALE
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Bit stream
  input  wire logic              bit_valid_i,
  input  wire logic              rx_bit_i,
  input  wire logic              exp_bit_i,
  input  wire logic [MEM_AW+4:0] pat_pos_i,
  input  wire logic              capture_active_i,
  // Results
  output logic                   err_o,
  output logic                   sync_o,
  output logic                   resync_o,
  output logic                   irq_o
);

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  bec_state_s s;
  bec_state_s n;

  logic [32:0]       rd_word;
  logic              mem_we;
  logic [32:0]       mem_wdata;
  logic [32:0]       mem_wen;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] pow10(input logic [3:0] e);
    logic [31:0] r;
    r = 32'h0000_0001;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < e) begin
        r = 32'(r * 32'd10);
      end
    end
    return r;
  endfunction : pow10

  bec_mask_mem #(
    .W  (33),
    .AW (MEM_AW)
  ) u_mask_mem (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (mem_we),
    .waddr_i   (s.mask_addr[MEM_AW-1:0]),
    .wdata_i   (mem_wdata),
    .wbit_en_i (mem_wen),
    .raddr_i   (pat_pos_i[MEM_AW+4:5]),
    .rdata_o   (rd_word)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        acc;
    logic        wr;
    logic [31:0] wd;
    logic [31:0] img;
    logic        mask_locked;
    logic        refuse;
    logic        ev_lost;
    logic        ev_gain;
    logic        mism;
    logic        excl;
    logic        cnt_err;
    logic        is_a;
    logic        is_b;
    logic [31:0] win_len;
    logic [31:0] thr;
    logic [31:0] werr;
    logic [31:0] ivl_len;
    logic [2:0]  clr;
    logic [2:0]  ev;

    n           = s;
    acc         = cyc_i && stb_i;
    wr          = acc && we_i && s.ack;
    wd          = dat_i;
    img         = 32'h0000_0000;
    refuse      = 1'b0;
    ev_lost     = 1'b0;
    ev_gain     = 1'b0;
    clr         = 3'h0;
    mem_we      = 1'b0;
    mem_wdata   = '0;
    mem_wen     = '0;
    n.resync    = 1'b0;
    mask_locked = (s.pat_kind == `BEC_PAT_PRBS) || (s.pat_kind == `BEC_PAT_MIXED) || capture_active_i;

    // ----------------------------------------------------------------
    // Register writes, taken at the edge where ack is sampled
    // ----------------------------------------------------------------
    if (wr) begin
      unique case ({adr_i[7:2], 2'b00})
        `BEC_A_CTRL: begin
          img[`BEC_C_TRANS]       = s.cls_trans;
          img[`BEC_C_COMB]        = s.combined;
          img[`BEC_C_WMASK]       = s.wmask_en;
          img[`BEC_C_WGATE]       = s.wgate_en;
          img[`BEC_C_AUTO]        = s.auto_sync;
          img[`BEC_C_EISEL +: 2]  = s.ei_sel;
          img[`BEC_C_THR +: 4]    = s.thr_sel;
          img[`BEC_C_PAT +: 2]    = s.pat_kind;
          img[`BEC_C_FRAME]       = s.frame_mode;
          wd = merge(img, dat_i, sel_i);
          n.combined   = wd[`BEC_C_COMB];
          n.wgate_en   = wd[`BEC_C_WGATE];
          n.auto_sync  = wd[`BEC_C_AUTO];
          n.ei_sel     = wd[`BEC_C_EISEL +: 2];
          n.pat_kind   = wd[`BEC_C_PAT +: 2];
          n.frame_mode = wd[`BEC_C_FRAME];
          // Transition mode is dropped, not kept, when combined mode is set
          n.cls_trans  = wd[`BEC_C_TRANS] && !wd[`BEC_C_COMB];
          if (wd[`BEC_C_TRANS] && wd[`BEC_C_COMB]) begin
            refuse = 1'b1;
          end
          if (wd[`BEC_C_WMASK] != s.wmask_en) begin
            if (mask_locked) begin
              refuse = 1'b1;
            end else begin
              n.wmask_en = wd[`BEC_C_WMASK];
            end
          end
          if ((wd[`BEC_C_THR +: 4] == `BEC_THR_INT) ||
              ((wd[`BEC_C_THR +: 4] >= `BEC_THR_NMIN) && (wd[`BEC_C_THR +: 4] <= `BEC_THR_NMAX))) begin
            n.thr_sel = wd[`BEC_C_THR +: 4];
          end else begin
            refuse = 1'b1;
          end
          if (wd[`BEC_C_RESYNC]) begin
            n.sync     = BEC_SY_HUNT;
            n.resync   = 1'b1;
            n.win_cnt  = 32'h0000_0000;
            n.win_err  = 32'h0000_0000;
          end
          if (wd[`BEC_C_CLR]) begin
            n.err_total = 32'h0000_0000;
            n.err_a     = 32'h0000_0000;
            n.err_b     = 32'h0000_0000;
            n.ei_cnt    = 32'h0000_0000;
            n.efi_cnt   = 32'h0000_0000;
          end
        end
        `BEC_A_DATA_LEN: begin
          wd = merge({13'h0000, s.data_len}, dat_i, sel_i);
          n.data_len = wd[18:0];
        end
        `BEC_A_MASK_ADDR: begin
          wd = merge({s.mask_gate, 15'h0000, s.mask_addr}, dat_i, sel_i);
          n.mask_addr = wd[`BEC_MA_AW-1:0];
          n.mask_gate = wd[`BEC_MA_GATE];
        end
        `BEC_A_MASK_DATA: begin
          mem_we    = 1'b1;
          mem_wdata = {s.mask_gate, dat_i};
          mem_wen[32] = 1'b1;
          if (mask_locked) begin
            refuse = 1'b1;
          end else begin
            for (int b = 0; b < 4; b++) begin
              mem_wen[b*8 +: 8] = {8{sel_i[b]}};
            end
          end
        end
        `BEC_A_INT_EN: begin
          wd = merge({29'h0000_0000, s.int_en}, dat_i, sel_i);
          n.int_en = wd[2:0];
        end
        `BEC_A_INT_CLR: begin
          clr = dat_i[2:0] & {3{sel_i[0]}};
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Bit pipeline, aligned with the registered mask read
    // ----------------------------------------------------------------
    n.p_valid = bit_valid_i;
    n.p_rx    = rx_bit_i;
    n.p_exp   = exp_bit_i;
    n.p_bit   = pat_pos_i[4:0];
    n.err_flag = 1'b0;
    mism = s.p_valid && (s.p_rx != s.p_exp);
    excl = (s.wmask_en && rd_word[s.p_bit]) ||
           (s.wgate_en && !rd_word[32]);
    cnt_err = mism && (s.sync == BEC_SY_LOCK) && !excl;
    if (s.cls_trans) begin
      is_a = s.p_exp != s.p_prev;
      is_b = s.p_exp == s.p_prev;
    end else begin
      is_a = !s.p_exp && s.p_rx;
      is_b = s.p_exp && !s.p_rx;
    end
    if (s.p_valid) begin
      n.p_prev = s.p_exp;
    end
    if (cnt_err) begin
      n.err_flag  = 1'b1;
      n.err_total = n.err_total + 32'h0000_0001;
      n.err_a     = is_a ? n.err_a + 32'h0000_0001 : n.err_a;
      n.err_b     = is_b ? n.err_b + 32'h0000_0001 : n.err_b;
      n.ivl_hit   = 1'b1;
    end

    // ----------------------------------------------------------------
    // Error and clean interval counting
    // ----------------------------------------------------------------
    unique case (s.ei_sel)
      2'h0:    ivl_len = 32'(IVL0_CYC);
      2'h1:    ivl_len = 32'(IVL1_CYC);
      2'h2:    ivl_len = 32'(IVL2_CYC);
      default: ivl_len = 32'(IVL3_CYC);
    endcase
    if (s.ivl_cnt + 32'h0000_0001 >= ivl_len) begin
      n.ivl_cnt = 32'h0000_0000;
      // One count per interval, however many errors fell in it
      if (s.ivl_hit || cnt_err) begin
        n.ei_cnt = n.ei_cnt + 32'h0000_0001;
      end else begin
        n.efi_cnt = n.efi_cnt + 32'h0000_0001;
      end
      n.ivl_hit = 1'b0;
    end else begin
      n.ivl_cnt = s.ivl_cnt + 32'h0000_0001;
    end

    // ----------------------------------------------------------------
    // Sync supervision: raw mismatches over a bit-count window
    // ----------------------------------------------------------------
    if (s.thr_sel == `BEC_THR_INT) begin
      if (s.frame_mode) begin
        win_len = (s.sync == BEC_SY_LOCK) ? 32'(FRM_LOSS_WIN) :
                  32'({13'h0000, s.data_len} * `BEC_FRM_GAIN_MUL);
        thr     = (s.sync == BEC_SY_LOCK) ? 32'(`BEC_FRM_LOSS_ERR) : 32'(`BEC_FRM_GAIN_ERR);
      end else begin
        win_len = (s.sync == BEC_SY_LOCK) ? 32'(PRBS_LOSS_WIN) : 32'(PRBS_GAIN_WIN);
        thr     = (s.sync == BEC_SY_LOCK) ? 32'(`BEC_PRBS_LOSS_ERR) : 32'(`BEC_PRBS_GAIN_ERR);
      end
    end else begin
      win_len = 32'(pow10(s.thr_sel) * 32'(DEC_SCALE));
      thr     = 32'(DEC_SCALE);
    end
    werr = s.win_err + {31'h0000_0000, mism};
    if (s.p_valid && !n.resync && (s.sync != BEC_SY_LOST)) begin
      if (s.win_cnt + 32'h0000_0001 >= win_len) begin
        n.win_cnt = 32'h0000_0000;
        n.win_err = 32'h0000_0000;
        if (s.sync == BEC_SY_LOCK && werr > thr) begin
          ev_lost = 1'b1;
          if (s.auto_sync) begin
            n.sync   = BEC_SY_HUNT;
            n.resync = 1'b1;
          end else begin
            n.sync = BEC_SY_LOST;
          end
        end else if (s.sync == BEC_SY_HUNT && werr <= thr) begin
          ev_gain = 1'b1;
          n.sync  = BEC_SY_LOCK;
        end
      end else begin
        n.win_cnt = s.win_cnt + 32'h0000_0001;
        n.win_err = werr;
      end
    end

    // ----------------------------------------------------------------
    // Interrupt status: a new event wins over a clear in the same cycle
    // ----------------------------------------------------------------
    ev = 3'h0;
    ev[`BEC_S_LOST]   = ev_lost;
    ev[`BEC_S_GAIN]   = ev_gain;
    ev[`BEC_S_REFUSE] = refuse;
    n.status = (s.status & ~clr) | ev;

    // ----------------------------------------------------------------
    // Bus answer: ack one cycle after the request is seen, dropped next
    // ----------------------------------------------------------------
    n.ack = acc && !s.ack;
    if (acc && !s.ack) begin
      unique case ({adr_i[7:2], 2'b00})
        `BEC_A_CTRL: begin
          n.dat = 32'h0000_0000;
          n.dat[`BEC_C_TRANS]      = s.cls_trans;
          n.dat[`BEC_C_COMB]       = s.combined;
          n.dat[`BEC_C_WMASK]      = s.wmask_en;
          n.dat[`BEC_C_WGATE]      = s.wgate_en;
          n.dat[`BEC_C_AUTO]       = s.auto_sync;
          n.dat[`BEC_C_EISEL +: 2] = s.ei_sel;
          n.dat[`BEC_C_THR +: 4]   = s.thr_sel;
          n.dat[`BEC_C_PAT +: 2]   = s.pat_kind;
          n.dat[`BEC_C_FRAME]      = s.frame_mode;
        end
        `BEC_A_DATA_LEN:  n.dat = {13'h0000, s.data_len};
        `BEC_A_MASK_ADDR: n.dat = {s.mask_gate, 15'h0000, s.mask_addr};
        `BEC_A_STATUS:    n.dat = {29'h0000_0000, s.status};
        `BEC_A_INT_EN:    n.dat = {29'h0000_0000, s.int_en};
        `BEC_A_SYNC:      n.dat = {29'h0000_0000, s.sync, s.sync == BEC_SY_LOCK};
        `BEC_A_ERR_TOTAL: n.dat = s.err_total;
        `BEC_A_ERR_A:     n.dat = s.err_a;
        `BEC_A_ERR_B:     n.dat = s.err_b;
        `BEC_A_EI_CNT:    n.dat = s.ei_cnt;
        `BEC_A_EFI_CNT:   n.dat = s.efi_cnt;
        default:          n.dat = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s          <= '0;
      s.data_len <= `BEC_DLEN_RST;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dat_o    = s.dat;
  assign ack_o    = s.ack;
  assign err_o    = s.err_flag;
  assign sync_o   = (s.sync == BEC_SY_LOCK);
  assign resync_o = s.resync;
  assign irq_o    = |(s.status & s.int_en);

endmodule : bec_top

`default_nettype wire

//--- test/bec_top_checker.sv
// Purpose: Port-level checks of the bit error classifier.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every bec_top instance.
`timescale 1ns/1ps
`default_nettype none
module bec_top_checker (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Stream and results
  input wire logic bit_valid_i,
  input wire logic rx_bit_i,
  input wire logic exp_bit_i,
  input wire logic err_o,
  input wire logic sync_o,
  input wire logic resync_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_err_cause; err_o |-> $past(bit_valid_i, 2) && ($past(rx_bit_i, 2) != $past(exp_bit_i, 2)); endproperty
  a_err_cause: assert property (p_err_cause) else $error("error pulse without mismatch");
  property p_err_synced; err_o |-> $past(sync_o) || $past(sync_o, 2) || $past(sync_o, 3); endproperty
  a_err_synced: assert property (p_err_synced) else $error("error counted while unsynced");
  property p_resync_pulse; resync_o |=> !resync_o; endproperty
  a_resync_pulse: assert property (p_resync_pulse) else $error("resync pulse too long");
  property p_resync_drop; resync_o |-> !sync_o; endproperty
  a_resync_drop: assert property (p_resync_drop) else $error("resync while synced");
  property p_quiet; $past(rst_i) |-> !sync_o && !irq_o && !err_o; endproperty
  a_quiet: assert property (p_quiet) else $error("outputs active after reset");
endmodule : bec_top_checker
bind bec_top bec_top_checker bec_top_checker_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .bit_valid_i(bit_valid_i), .rx_bit_i(rx_bit_i), .exp_bit_i(exp_bit_i), .err_o(err_o),
  .sync_o(sync_o), .resync_o(resync_o), .irq_o(irq_o));
`default_nettype wire

//--- test/bec_dut_model.sv
// Purpose: Pattern source standing in for the device under test.
// Assumes: One bit per clock while run_i is high.
// Notes:   Idle data line toggles so a stale bit never looks valid.
`timescale 1ns/1ps
`default_nettype none
module bec_dut_model (
  // Control
  input  wire logic   clk_i,
  input  wire logic   run_i,
  input  wire logic   flip_i,
  // Stream
  output logic        valid_o,
  output logic        rx_o,
  output logic        exp_o,
  output logic [10:0] pos_o
);
  logic e;
  initial valid_o = 1'b0;
  initial pos_o = 11'h000;
  initial rx_o = 1'b0;
  always @(posedge clk_i) begin
    e = 1'($urandom);
    valid_o <= run_i;
    exp_o   <= e;
    rx_o    <= run_i ? e ^ flip_i : ~rx_o;
    pos_o   <= pos_o + 11'h001;
  end
endmodule : bec_dut_model
`default_nettype wire

//--- test/bec_top_test.sv
// Purpose: Self-checking bench for the bit error classifier.
// Assumes: Short interval parameter keeps the run brief; the short PRBS windows go unused, as sync runs at ten to minus 2.
// Notes:   Bus reads and counted errors are checked against queued notes.
`timescale 1ns/1ps
`default_nettype none
module bec_top_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, flip = 1'b0, track = 1'b0, mode = 1'b0, pexp = 1'b0;
  logic        capt = 1'b0;
  logic [3:0]  sel = 4'hF;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack, valid, rx, expb, err, sync, resync, irq;
  logic [10:0] pos;
  int          n_errors = 0, comparisons = 0, n_a = 0, n_b = 0, n_resync = 0;
  logic [31:0] q_rd[$];
  logic [31:0] q_err[$];
  always #4 clk_i = ~clk_i;
  bec_top #(.IVL0_CYC(20), .PRBS_LOSS_WIN(200), .PRBS_GAIN_WIN(64)) bec_top_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
    .bit_valid_i(valid), .rx_bit_i(rx), .exp_bit_i(expb), .pat_pos_i(pos), .capture_active_i(capt), .err_o(err),
    .sync_o(sync), .resync_o(resync), .irq_o(irq));
  bec_dut_model bec_dut_model_i (.clk_i(clk_i), .run_i(run), .flip_i(flip), .valid_o(valid), .rx_o(rx),
    .exp_o(expb), .pos_o(pos));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m = 4'hF);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= m;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      finish_test();
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic stream(input int n, input int every);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      flip <= (every > 0) && (i % every == 0);
    end
    @(posedge clk_i);
    flip <= 1'b0;
  endtask : stream
  // Expected error pulse lands two edges after the bit is taken
  always @(posedge clk_i) begin
    if (ack === 1'b1 && !we && q_rd.size() > 0) chk("read data", q_rd.pop_front(), rdat);
    if (valid === 1'b1 && sync === 1'b1 && track && rx !== expb) begin
      q_err.push_back(32'($time + 16));
      if (mode ? expb != pexp : !expb) n_a++;
      else n_b++;
    end
    if (valid === 1'b1) pexp <= expb;
    if (err === 1'b1 && track) chk("error pulse time", q_err.size() > 0 ? q_err.pop_front() : 32'h0, 32'($time));
    if (resync === 1'b1) n_resync++;
  end
  initial begin
    void'($urandom(85));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0080);
    rd(8'h40, 32'h0000_0000);
    $display("Reset values done");
    bus(1'b1, 8'h00, 32'h0000_0413);
    rd(8'h00, 32'h0000_0412);
    rd(8'h10, 32'h0000_0004);
    $display("Refused setting done");
    bus(1'b1, 8'h00, 32'h0000_0410);
    run <= 1'b1;
    for (int k = 0; k < 4000 && sync !== 1'b1; k++) @(posedge clk_i);
    chk("sync gained", 32'h1, {31'h0, sync});
    rd(8'h10, 32'h0000_0006);
    for (int m = 0; m < 2; m++) begin
      stream(1100, 0);
      bus(1'b1, 8'h00, 32'h0000_0490 | m);
      n_a = 0;
      n_b = 0;
      mode <= m[0];
      track <= 1'b1;
      stream(160, 20);
      repeat (4) @(posedge clk_i);
      track <= 1'b0;
      rd(8'h20, 32'h0000_0008);
      rd(8'h24, n_a);
      rd(8'h28, n_b);
      $display("Error classes done for mode %0d", m);
    end
    chk("queued errors left", 32'h0, q_err.size());
    bus(1'b1, 8'h14, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("masked irq", 32'h0, {31'h0, irq});
    stream(1100, 1);
    chk("sync lost", 32'h0, {31'h0, sync});
    chk("resync pulses", 32'h1, n_resync);
    chk("irq raised", 32'h1, {31'h0, irq});
    run <= 1'b0;
    rd(8'h10, 32'h0000_0007);
    bus(1'b1, 8'h18, 32'h0000_0007);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(8'h10, 32'h0000_0000);
    $display("Loss and interrupt done");
    bus(1'b1, 8'h04, 32'hFFFF_FF05, 4'h1);
    rd(8'h04, 32'h0000_0005);
    capt <= 1'b1;
    bus(1'b1, 8'h00, 32'h0000_0414);
    rd(8'h00, 32'h0000_0410);
    rd(8'h10, 32'h0000_0004);
    capt <= 1'b0;
    // Clear, then 200 updates before the read captures: exactly ten 20-cycle intervals
    bus(1'b1, 8'h00, 32'h0000_0490);
    repeat (198) @(posedge clk_i);
    rd(8'h30, 32'h0000_000A);
    rd(8'h2C, 32'h0000_0000);
    $display("Lanes, mask lock and intervals done");
    finish_test();
  end
endmodule : bec_top_test
`default_nettype wire
